// [bench/etcol_host.sv]
// Host model that writes the compare registers
`timescale 1ns/10ps
module etcol_host
  import etcol_pkg::*;
(
  input  wire logic    clock,
  output etcol_regwr_s regWr
);
  initial regWr = '0;
  // One pulse per register, high before low
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    #5 regWr = {1'b1, a, d};
    @(posedge clock);
    #5 regWr = {1'b0, ~a, ~d};
  endtask : wr
endmodule : etcol_host

// [bench/event_timer_compare_one_load_test.sv]
// Self-checking bench for the compare-one load block
`timescale 1ns/10ps
module event_timer_compare_one_load_test;
  import etcol_pkg::*;
  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  logic [5:0]   rdA   = 6'h00;
  logic [23:0]  tmr   = 24'h000000;
  logic [23:0]  val;
  logic [15:0]  rdD;
  logic         off;
  logic         hit;
  etcol_regwr_s regWr;
  int           mismatches = 0;
  int           checksDone = 0;
  int           cycles     = 0;
  always #25 clock = ~clock;
  etcol_host etcol_host_i (.clock(clock), .regWr(regWr));
  etcol_compare_one etcol_compare_one_i (.clock(clock), .rst_n(rst_n), .regWr(regWr),
    .regRdAddr(rdA), .eventTimer(tmr), .regRdData_r(rdD),
    .compareOneMatchValue_r(val), .compareOneActiveOff_r(off), .matchEvent_r(hit));
  task automatic results;
    $display("checks %0d mismatches %0d", checksDone, mismatches);
    if (mismatches == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    checksDone++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    rdA = a;
    @(posedge clock);
    #5 chk({9'h0, rdD}, {9'h0, exp});
  endtask : rd
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      results();
    end
  end
  task automatic tReset;
    rd(HIGH_REG_ADDR, 16'h00ff);
    rd(LOW_REG_ADDR, 16'hffff);
    rd(6'h1d, 16'h0000);
    chk({off, val}, {1'b0, 24'hffffff});
    etcol_host_i.wr(HIGH_REG_ADDR, 16'h80ff);
    chk({off, val}, {1'b0, 24'hffffff});
    etcol_host_i.wr(LOW_REG_ADDR, 16'hffff);
    chk({off, val}, {1'b1, 24'hffffff});
    $display("reset test done");
  endtask : tReset
  task automatic tStage;
    etcol_host_i.wr(HIGH_REG_ADDR, 16'h8012);
    chk({off, val}, {1'b1, 24'hffffff});
    rd(HIGH_REG_ADDR, 16'h8012);
    etcol_host_i.wr(LOW_REG_ADDR, 16'h3456);
    chk({off, val}, {1'b1, 24'h123456});
    $display("staged load test done");
  endtask : tStage
  task automatic tLone;
    tmr = 24'h123456;
    @(posedge clock);
    #5 chk({24'h0, hit}, 25'h0);
    etcol_host_i.wr(LOW_REG_ADDR, 16'h0005);
    chk({off, val}, {1'b1, 24'h120005});
    etcol_host_i.wr(HIGH_REG_ADDR, 16'h0000);
    etcol_host_i.wr(LOW_REG_ADDR, 16'h0010);
    chk({off, val}, {1'b0, 24'h000010});
    tmr = 24'h000010;
    @(posedge clock);
    #5 chk({24'h0, hit}, 25'h1);
    @(posedge clock);
    #5 chk({24'h0, hit}, 25'h0);
    $display("lone write and match test done");
  endtask : tLone
  initial begin
    repeat (20) @(posedge clock);
    #5 rst_n = 1'b1;
    tReset();
    tStage();
    tLone();
    results();
  end
endmodule : event_timer_compare_one_load_test

// [rtl/etcol_compare_one.sv]
// Compare-one match value registers, staged load and match detector
`timescale 1ns/10ps
module etcol_compare_one
  import etcol_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire etcol_regwr_s       regWr,
  input  wire logic [ADDR_W-1:0]  regRdAddr,
  input  wire logic [MATCH_W-1:0] eventTimer,
  output logic      [DATA_W-1:0]  regRdData_r,
  output logic      [MATCH_W-1:0] compareOneMatchValue_r,
  output logic                    compareOneActiveOff_r,
  output logic                    matchEvent_r
);
  logic                 compareOneOff_r;
  logic [7:0]           highByte_r;
  logic [DATA_W-1:0]    compareOneLowWord_r;
  logic                 equalPrev_r;
  logic                 highWrite;
  logic                 lowWrite;
  logic                 equalNow;
  logic [DATA_W-1:0]    highView;
  logic [DATA_W-1:0]    regRdData_nxt;

  // Shared address decode for the write strobe and the read mux
  function automatic logic addrIs(input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] target);
    return addr == target;
  endfunction : addrIs

  assign highWrite = regWr.write && addrIs(regWr.addr, HIGH_REG_ADDR);
  assign lowWrite  = regWr.write && addrIs(regWr.addr, LOW_REG_ADDR);
  // Reserved bits 14:8 read as zero
  assign highView  = {compareOneOff_r, 7'h00, highByte_r};

  // Staged high register: writes here never touch the active comparator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compareOneOff_r <= OFF_RESET;
      highByte_r      <= HIGH_BYTE_RESET;
    end else if (highWrite) begin
      compareOneOff_r <= regWr.data[OFF_BIT];
      highByte_r      <= regWr.data[HIGH_BYTE_MSB:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compareOneLowWord_r <= LOW_WORD_RESET;
    end else if (lowWrite) begin
      compareOneLowWord_r <= regWr.data;
    end
  end

  // Active comparator loads all fields in parallel on a low write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compareOneMatchValue_r <= ACTIVE_RESET;
      compareOneActiveOff_r  <= OFF_RESET;
    end else if (lowWrite) begin
      compareOneMatchValue_r <= {highByte_r, regWr.data};
      compareOneActiveOff_r  <= compareOneOff_r;
    end
  end

  // One pulse when the timer arrives at the value, not every cycle it rests there
  assign equalNow = !compareOneActiveOff_r && (eventTimer == compareOneMatchValue_r);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      equalPrev_r  <= 1'b0;
      matchEvent_r <= 1'b0;
    end else begin
      equalPrev_r  <= equalNow;
      matchEvent_r <= equalNow && !equalPrev_r;
    end
  end

  always_comb begin
    if (addrIs(regRdAddr, HIGH_REG_ADDR)) begin
      regRdData_nxt = highView;
    end else if (addrIs(regRdAddr, LOW_REG_ADDR)) begin
      regRdData_nxt = compareOneLowWord_r;
    end else begin
      regRdData_nxt = '0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      regRdData_r <= '0;
    end else begin
      regRdData_r <= regRdData_nxt;
    end
  end

  chk_high_stage_only: assert property (@(posedge clock) disable iff (!rst_n)
    highWrite && !lowWrite |=> $stable(compareOneMatchValue_r) && $stable(compareOneActiveOff_r))
    else $error("high write changed the active comparator");

  chk_low_load_value: assert property (@(posedge clock) disable iff (!rst_n)
    lowWrite |=> compareOneMatchValue_r == {$past(highByte_r), $past(regWr.data)})
    else $error("low write did not load the full match value");

  chk_low_load_off: assert property (@(posedge clock) disable iff (!rst_n)
    lowWrite |=> compareOneActiveOff_r == $past(compareOneOff_r))
    else $error("low write did not apply the staged off control");

  chk_off_bit_store: assert property (@(posedge clock) disable iff (!rst_n)
    highWrite |=> ##1 ($past(regRdAddr) != HIGH_REG_ADDR ||
                       regRdData_r[OFF_BIT] == $past(regWr.data[OFF_BIT], 2)))
    else $error("off control not read back in bit 15");

  chk_high_byte_store: assert property (@(posedge clock) disable iff (!rst_n)
    highWrite |=> highByte_r == $past(regWr.data[HIGH_BYTE_MSB:0])
                  && (!addrIs(regRdAddr, HIGH_REG_ADDR)
                      || regRdData_nxt[OFF_BIT-1:HIGH_BYTE_MSB+1] == 7'h00))
    else $error("high byte not stored");

  chk_low_word_store: assert property (@(posedge clock) disable iff (!rst_n)
    lowWrite |=> compareOneLowWord_r == $past(regWr.data))
    else $error("low word not stored");

  chk_match_pulse: assert property (@(posedge clock) disable iff (!rst_n)
    matchEvent_r |-> $past(eventTimer) == $past(compareOneMatchValue_r)
                     && !$past(compareOneActiveOff_r) ##1 !matchEvent_r)
    else $error("match pulse without an enabled equal timer");

  chk_off_blocks: assert property (@(posedge clock) disable iff (!rst_n)
    compareOneActiveOff_r && $past(compareOneActiveOff_r) |-> !matchEvent_r)
    else $error("match while comparator disabled");

  chk_active_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !lowWrite
    |=> $stable(compareOneMatchValue_r) && $stable(compareOneActiveOff_r))
    else $error("active comparator changed without a low write");

  chk_staged_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !highWrite
    |=> $stable(compareOneOff_r) && $stable(highByte_r))
    else $error("staged high register changed without a high write");

  chk_low_word_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !lowWrite
    |=> $stable(compareOneLowWord_r))
    else $error("low word changed without a low write");

  chk_read_high_view: assert property (
    @(posedge clock) disable iff (!rst_n)
    addrIs(regRdAddr, HIGH_REG_ADDR)
    |=> regRdData_r[OFF_BIT] == $past(compareOneOff_r) && regRdData_r[HIGH_BYTE_MSB:0] == $past(highByte_r))
    else $error("high register read back wrong");

  chk_reserved_zero: assert property (
    @(posedge clock) disable iff (!rst_n)
    addrIs(regRdAddr, HIGH_REG_ADDR)
    |=> regRdData_r[OFF_BIT-1:HIGH_BYTE_MSB+1] == 7'h00)
    else $error("reserved high register bits not zero");

  chk_read_low_word: assert property (
    @(posedge clock) disable iff (!rst_n)
    addrIs(regRdAddr, LOW_REG_ADDR)
    |=> regRdData_r == $past(compareOneLowWord_r))
    else $error("low register read back wrong");

  chk_match_on_arrival: assert property (
    @(posedge clock) disable iff (!rst_n)
    !compareOneActiveOff_r && eventTimer == compareOneMatchValue_r && !equalPrev_r
    |=> matchEvent_r)
    else $error("no match pulse on arrival at the value");

  chk_single_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    matchEvent_r
    |=> !matchEvent_r)
    else $error("match pulse longer than one cycle");

  chk_off_no_match: assert property (
    @(posedge clock) disable iff (!rst_n)
    compareOneActiveOff_r
    |=> !matchEvent_r)
    else $error("match pulse from a disabled comparator");

  chk_low_copy_off: assert property (
    @(posedge clock) disable iff (!rst_n)
    lowWrite && compareOneOff_r
    |=> compareOneActiveOff_r)
    else $error("low write did not disable the comparator");

  chk_low_copy_on: assert property (
    @(posedge clock) disable iff (!rst_n)
    lowWrite && !compareOneOff_r
    |=> !compareOneActiveOff_r)
    else $error("low write did not enable the comparator");

  chk_lone_high_byte: assert property (
    @(posedge clock) disable iff (!rst_n)
    lowWrite
    |=> compareOneMatchValue_r[MATCH_W-1:DATA_W] == $past(highByte_r))
    else $error("low write did not use the present high byte");

  chk_low_half_match: assert property (
    @(posedge clock) disable iff (!rst_n)
    1'b1
    |-> compareOneMatchValue_r[DATA_W-1:0] == compareOneLowWord_r)
    else $error("active low half differs from the low register");
endmodule : etcol_compare_one

// [rtl/etcol_pkg.sv]
// Constants and carrier types for the first event-timer comparator load block
package etcol_pkg;
  localparam int          ADDR_W          = 6;
  localparam int          DATA_W          = 16;
  localparam int          MATCH_W         = 24;
  localparam logic [5:0]  HIGH_REG_ADDR   = 6'h1b;
  localparam logic [5:0]  LOW_REG_ADDR    = 6'h1c;
  localparam int          OFF_BIT         = 15;
  localparam int          HIGH_BYTE_MSB   = 7;
  localparam logic        OFF_RESET       = 1'b0;
  localparam logic [7:0]  HIGH_BYTE_RESET = 8'hff;
  localparam logic [15:0] LOW_WORD_RESET  = 16'hffff;
  localparam logic [23:0] ACTIVE_RESET    = 24'hffffff;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } etcol_regwr_s;
endpackage : etcol_pkg
